// file: epps_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
`include "epp_seq_map.svh"
module epps_sequencer
  import epps_pkg::*;
#(
  parameter int TMOUT_CYC = `EPPS_TMOUT_CYC
)(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [4:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             iochrdy_o,
  input  wire logic [7:0]  port_data_bus_i,
  output logic      [7:0]  port_data_bus_o,
  output logic             port_data_bus_oe_o,
  output logic             port_direction_out_o,
  output logic             write_n_o,
  output logic             data_strobe_n_o,
  output logic             addr_strobe_n_o,
  output logic             strobe_n_o,
  output logic             autofd_n_o,
  output logic             init_n_o,
  output logic             slctin_n_o,
  input  wire logic        wait_n_i,
  input  wire logic        intr_i,
  output logic             intr_o,
  output logic             periph_reset_n_o
);
  // ==========================================================
  // bus decode
  logic        req;
  logic [2:0]  idx;
  logic        epp_hit;
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign idx = wb_adr_i[4:2];
  assign epp_hit = (idx == `EPPS_EADDR_ADR) | (idx == `EPPS_EDATA_ADR);

  logic [5:0]  ctrl;
  logic [7:0]  dreg;
  logic [1:0]  mode;
  logic        tmout;
  logic [7:0]  rd_byte;
  logic [7:0]  wr_byte;
  logic        is_rd;
  logic        is_addr;
  logic        v17;
  logic        active;
  logic        done_pulse;
  logic        abort;
  epps_state_type state;
  epps_state_type next_state;
  logic [$clog2(TMOUT_CYC+1)-1:0] tcnt;

  assign v17    = mode[`EPPS_MODE_V17];
  assign active = (state != EPPS_IDLE);

  // ==========================================================
  // software registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl <= `EPPS_CTRL_RST;
      dreg <= 8'h00;
      mode <= `EPPS_MODE_RST;
    end
    else if (req & wb_we_i & wb_sel_i[0] & ~epp_hit)
    begin
      unique case (idx)
        `EPPS_DATA_ADR: dreg <= wb_dat_i[7:0];
        `EPPS_CTRL_ADR: ctrl <= wb_dat_i[5:0];
        `EPPS_MODE_ADR: mode <= wb_dat_i[1:0];
        default:        ;
      endcase
    end
  end

  // timeout flag: set wins over write-one-to-clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      tmout <= 1'b0;
    else if (abort)
      tmout <= 1'b1;
    else if (req & wb_we_i & wb_sel_i[0] & (idx == `EPPS_STAT_ADR)
             & wb_dat_i[`EPPS_STAT_TMOUT])
      tmout <= 1'b0;
  end

  // ==========================================================
  // cycle sequencer
  // the host bus request itself stands for nIOR/nIOW; ack is its release
  always_comb
  begin
    next_state = state;
    done_pulse = 1'b0;
    unique case (state)
      EPPS_IDLE:
        if (req & epp_hit)
          next_state = v17 ? EPPS_STRB : EPPS_PREP;
      EPPS_PREP:
        if (abort)
          next_state = EPPS_DONE;
        else if (~wait_n_i)
          next_state = EPPS_STRB;
      EPPS_STRB:
        if (abort)
          next_state = EPPS_DONE;
        else if (wait_n_i)
          next_state = v17 ? EPPS_DONE : EPPS_TERM;
      EPPS_TERM:
        next_state = EPPS_DONE;
      EPPS_DONE:
      begin
        done_pulse = 1'b1;
        next_state = EPPS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      state <= EPPS_IDLE;
    else
      state <= next_state;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      is_rd   <= 1'b0;
      is_addr <= 1'b0;
      wr_byte <= 8'h00;
    end
    else if (state == EPPS_IDLE && req && epp_hit)
    begin
      // with the direction bit set a write degrades to a read
      is_rd   <= ~wb_we_i | ctrl[`EPPS_CTRL_DIR];
      is_addr <= (idx == `EPPS_EADDR_ADR);
      wr_byte <= wb_dat_i[7:0];
    end
  end

  // ==========================================================
  // watchdog: cleared at each cycle start, counts host clock
  assign abort = active && (state != EPPS_DONE) && (tcnt >= TMOUT_CYC);
  always_ff @(posedge clk_i)
  begin
    if (rst_i || state == EPPS_IDLE)
      tcnt <= '0;
    else if (tcnt < TMOUT_CYC)
      tcnt <= tcnt + 1'b1;
  end

  // ==========================================================
  // read capture and bus answer
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rd_byte <= 8'h00;
    else if ((state == EPPS_STRB) && wait_n_i && is_rd)
      rd_byte <= port_data_bus_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= (req & ~epp_hit) | done_pulse;
      wb_dat_o <= 32'h0000_0000;
      if (done_pulse)
        wb_dat_o <= {24'h000000, rd_byte};
      else if (req & ~epp_hit)
      begin
        unique case (idx)
          `EPPS_DATA_ADR: wb_dat_o <= {24'h000000, dreg};
          `EPPS_STAT_ADR: wb_dat_o <= {27'h0, ~intr_i, 3'h0, tmout};
          `EPPS_CTRL_ADR: wb_dat_o <= {26'h0, ctrl};
          `EPPS_MODE_ADR: wb_dat_o <= {30'h0, mode};
          default:        wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ==========================================================
  // port pins, all registered
  logic strb_on;
  assign strb_on = (state == EPPS_STRB);
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      iochrdy_o            <= 1'b1;
      port_data_bus_o      <= 8'h00;
      port_data_bus_oe_o   <= 1'b1;
      port_direction_out_o <= 1'b0;
      write_n_o            <= 1'b1;
      data_strobe_n_o      <= 1'b1;
      addr_strobe_n_o      <= 1'b1;
      strobe_n_o           <= 1'b1;
      autofd_n_o           <= 1'b1;
      init_n_o             <= 1'b0;
      slctin_n_o           <= 1'b1;
      intr_o               <= 1'b0;
      periph_reset_n_o     <= 1'b0;
    end
    else
    begin
      // 1.9 holds ready low all cycle, 1.7 only while wait is low
      iochrdy_o <= v17 ? ~(active & ~wait_n_i & (state != EPPS_DONE))
                       : ~((next_state != EPPS_IDLE)
                           & (next_state != EPPS_DONE));
      data_strobe_n_o <= ~(strb_on & ~is_addr & ~abort &
                           ~(wait_n_i & ~v17));
      addr_strobe_n_o <= ~(strb_on & is_addr & ~abort &
                           ~(wait_n_i & ~v17));
      if (active && state != EPPS_DONE)
      begin
        port_data_bus_o      <= is_rd ? port_data_bus_o : wr_byte;
        port_data_bus_oe_o   <= ~is_rd;
        port_direction_out_o <= is_rd;
        // control strobe bit may still force write (override)
        write_n_o <= is_rd & ~ctrl[`EPPS_CTRL_STROBE];
      end
      else
      begin
        port_data_bus_o      <= (state == EPPS_DONE && !is_rd) ? wr_byte
                                : dreg;
        port_data_bus_oe_o   <= ~ctrl[`EPPS_CTRL_DIR];
        port_direction_out_o <= ctrl[`EPPS_CTRL_DIR];
        write_n_o            <= ctrl[`EPPS_CTRL_DIR];
      end
      strobe_n_o       <= ~ctrl[`EPPS_CTRL_STROBE];
      autofd_n_o       <= ~ctrl[`EPPS_CTRL_AUTOFD];
      init_n_o         <= ctrl[`EPPS_CTRL_INIT];
      slctin_n_o       <= ~ctrl[`EPPS_CTRL_SLCTIN];
      intr_o           <= intr_i;
      periph_reset_n_o <= ~mode[`EPPS_MODE_PRST];
    end
  end

  // ==========================================================
  // checks
  property p_abort_flags;
    @(posedge clk_i) disable iff (rst_i)
    abort |=> tmout;
  endproperty
  a_abort_flags: assert property (p_abort_flags)
    else $error("timeout not flagged");

  property p_prep_wait;
    @(posedge clk_i) disable iff (rst_i)
    (state == EPPS_PREP && wait_n_i && !abort) |=> state == EPPS_PREP;
  endproperty
  a_prep_wait: assert property (p_prep_wait)
    else $error("strobe before wait low");

  property p_rdy19;
    @(posedge clk_i) disable iff (rst_i)
    (!v17 && state == EPPS_STRB && !wait_n_i && !abort) |=> !iochrdy_o;
  endproperty
  a_rdy19: assert property (p_rdy19)
    else $error("ready released early");

  property p_rd_cap;
    @(posedge clk_i) disable iff (rst_i)
    (state == EPPS_STRB && wait_n_i && is_rd && !abort)
      |=> rd_byte == $past(port_data_bus_i);
  endproperty
  a_rd_cap: assert property (p_rd_cap)
    else $error("read byte not captured");

  property p_dir_rd;
    @(posedge clk_i) disable iff (rst_i)
    (state == EPPS_STRB && is_rd) |=> port_direction_out_o;
  endproperty
  a_dir_rd: assert property (p_dir_rd)
    else $error("direction low during read");

  property p_wr_drive;
    @(posedge clk_i) disable iff (rst_i)
    (state == EPPS_STRB && !is_rd)
      |=> port_data_bus_oe_o && port_data_bus_o == $past(wr_byte);
  endproperty
  a_wr_drive: assert property (p_wr_drive)
    else $error("write byte not driven");

  property p_cnt_clr;
    @(posedge clk_i) disable iff (rst_i)
    state == EPPS_IDLE |=> tcnt == 0;
  endproperty
  a_cnt_clr: assert property (p_cnt_clr)
    else $error("watchdog not cleared");

  property p_intr;
    @(posedge clk_i) disable iff (rst_i)
    !$past(rst_i) |-> intr_o == $past(intr_i);
  endproperty
  a_intr: assert property (p_intr)
    else $error("interrupt not passed");

  property p_rdy_start;
    @(posedge clk_i) disable iff (rst_i)
    (!v17 && state == EPPS_IDLE && req && epp_hit) |=> !iochrdy_o;
  endproperty
  a_rdy_start: assert property (p_rdy_start)
    else $error("ready not pulled at cycle start");

  property p_hold_strb;
    @(posedge clk_i) disable iff (rst_i)
    (!v17 && state == EPPS_STRB && !wait_n_i && !abort)
      |=> state == EPPS_STRB;
  endproperty
  a_hold_strb: assert property (p_hold_strb)
    else $error("cycle ended while wait low");

  property p_term19;
    @(posedge clk_i) disable iff (rst_i)
    (!v17 && state == EPPS_STRB && wait_n_i && !abort)
      |=> data_strobe_n_o && addr_strobe_n_o && state == EPPS_TERM;
  endproperty
  a_term19: assert property (p_term19)
    else $error("strobe not dropped at termination");

  property p_rd_float;
    @(posedge clk_i) disable iff (rst_i)
    (state == EPPS_STRB && is_rd && !ctrl[`EPPS_CTRL_STROBE])
      |=> !port_data_bus_oe_o && write_n_o;
  endproperty
  a_rd_float: assert property (p_rd_float)
    else $error("bus driven during read");

  property p_rdy17;
    @(posedge clk_i) disable iff (rst_i)
    (v17 && state == EPPS_STRB) |=> iochrdy_o == $past(wait_n_i);
  endproperty
  a_rdy17: assert property (p_rdy17)
    else $error("ready not following wait");

  property p_strb_end;
    @(posedge clk_i) disable iff (rst_i)
    state == EPPS_DONE |=> data_strobe_n_o && addr_strobe_n_o;
  endproperty
  a_strb_end: assert property (p_strb_end)
    else $error("strobe held past cycle end");

  property p_wr_ovr;
    @(posedge clk_i) disable iff (rst_i)
    (state == EPPS_STRB && ctrl[`EPPS_CTRL_STROBE]) |=> !write_n_o;
  endproperty
  a_wr_ovr: assert property (p_wr_ovr)
    else $error("write line not overridden");

  property p_idle_pins;
    @(posedge clk_i) disable iff (rst_i)
    state == EPPS_IDLE
      |=> port_direction_out_o == $past(ctrl[`EPPS_CTRL_DIR])
          && strobe_n_o == !$past(ctrl[`EPPS_CTRL_STROBE]);
  endproperty
  a_idle_pins: assert property (p_idle_pins)
    else $error("idle pins not from control");

  property p_prst;
    @(posedge clk_i) disable iff (rst_i)
    !$past(rst_i) |-> periph_reset_n_o == !$past(mode[`EPPS_MODE_PRST]);
  endproperty
  a_prst: assert property (p_prst)
    else $error("peripheral reset not from mode");
endmodule // epps_sequencer
`default_nettype wire

// file: epp_seq_map.svh
`ifndef EPP_SEQ_MAP_SVH
`define EPP_SEQ_MAP_SVH
// ==========================================================
// register offsets (word index, byte address = 4 * index)
`define EPPS_DATA_ADR    3'h0
`define EPPS_STAT_ADR    3'h1
`define EPPS_CTRL_ADR    3'h2
`define EPPS_EADDR_ADR   3'h3
`define EPPS_EDATA_ADR   3'h4
`define EPPS_MODE_ADR    3'h5
// ==========================================================
// fields
`define EPPS_STAT_TMOUT  0
`define EPPS_CTRL_STROBE 0
`define EPPS_CTRL_AUTOFD 1
`define EPPS_CTRL_INIT   2
`define EPPS_CTRL_SLCTIN 3
`define EPPS_CTRL_DIR    5
`define EPPS_MODE_V17    0
`define EPPS_MODE_PRST   1
// ==========================================================
// reset values
`define EPPS_CTRL_RST    6'h04
`define EPPS_MODE_RST    2'h0
// ==========================================================
// timing
`define EPPS_CLK_MHZ     250
`define EPPS_TMOUT_US    10
`define EPPS_TMOUT_CYC   (`EPPS_TMOUT_US * `EPPS_CLK_MHZ)
`endif

// file: epps_pkg.sv
`default_nettype none
package epps_pkg;
  typedef enum logic [4:0] {
    EPPS_IDLE = 5'h01,
    EPPS_PREP = 5'h02,
    EPPS_STRB = 5'h04,
    EPPS_TERM = 5'h08,
    EPPS_DONE = 5'h10
  } epps_state_type;
endpackage
`default_nettype wire

// file: epps_periph_model.sv
`timescale 1ns/100ps
`default_nettype none
// ====
// peripheral side of the port bus
module epps_periph_model (
  input  wire logic       clk_i,
  input  wire logic       data_strobe_n_i,
  input  wire logic       addr_strobe_n_i,
  input  wire logic       write_n_i,
  input  wire logic       bus_oe_i,
  input  wire logic [7:0] bus_d_i,
  input  wire logic [7:0] rdata_i,
  input  wire logic [2:0] delay_i,
  input  wire logic       stall_i,
  output logic            wait_n_o,
  output logic      [7:0] bus_o,
  output logic      [7:0] latched_o,
  output logic            latched_adr_o
);
  logic [3:0] cnt = 4'h0;
  logic       drive = 1'b0;
  logic [7:0] last = 8'h00;
  wire logic  strb;
  assign strb = !(data_strobe_n_i && addr_strobe_n_i);
  // floated bus toggles so a stale byte never matches by luck
  assign bus_o = bus_oe_i ? bus_d_i : (drive ? rdata_i : ~last);
  initial wait_n_o = 1'b0;
  always @(posedge clk_i)
  begin
    last <= bus_o;
    if (strb && !wait_n_o)
    begin
      drive <= write_n_i;
      cnt <= cnt + 4'h1;
      if (cnt > {1'b0, delay_i} && !stall_i)
      begin
        wait_n_o <= 1'b1;
        latched_o <= bus_d_i;
        latched_adr_o <= !addr_strobe_n_i;
      end
    end
    else if (!strb && wait_n_o)
    begin
      drive <= 1'b0;
      cnt <= cnt + 4'h1;
      // hold time stretched so a following cycle sees wait high
      if (cnt > {1'b0, delay_i})
      begin
        wait_n_o <= 1'b0;
        cnt <= 4'h0;
      end
    end
    else if (!strb)
    begin
      drive <= 1'b0;
      cnt <= 4'h0;
    end
    else
      cnt <= 4'h0;
  end
endmodule // epps_periph_model
`default_nettype wire

// file: tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [4:0]  wb_adr_i = 5'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic        intr_i = 1'b0;
  logic [7:0]  rdata = 8'h00;
  logic [2:0]  delay = 3'h0;
  logic        stall = 1'b0;
  logic [31:0] wb_dat_o;
  logic [7:0]  pd_o, pd_i, latched, b, r;
  logic        wb_ack_o, rdy, pd_oe, dir_o, wr_n, ds_n, as_n, lat_adr;
  logic        stb_n, afd_n, init_n, sl_n, wait_n, intr_o, prst_n;
  logic [32:0] note;
  logic [32:0] q[$];
  logic [5:0]  c;
  logic [2:0]  idx;
  logic        lo;
  int          failures = 0;
  int          n_tests = 0;
  int          lat;
  int          seed = 32'h1e75;
  always #2 clk_i = ~clk_i;
  epps_sequencer #(.TMOUT_CYC(20)) i_epps_sequencer (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .iochrdy_o(rdy), .port_data_bus_i(pd_i),
    .port_data_bus_o(pd_o), .port_data_bus_oe_o(pd_oe),
    .port_direction_out_o(dir_o), .write_n_o(wr_n),
    .data_strobe_n_o(ds_n), .addr_strobe_n_o(as_n),
    .strobe_n_o(stb_n), .autofd_n_o(afd_n), .init_n_o(init_n),
    .slctin_n_o(sl_n), .wait_n_i(wait_n), .intr_i(intr_i),
    .intr_o(intr_o), .periph_reset_n_o(prst_n));
  epps_periph_model i_epps_periph_model (
    .clk_i(clk_i), .data_strobe_n_i(ds_n), .addr_strobe_n_i(as_n),
    .write_n_i(wr_n), .bus_oe_i(pd_oe), .bus_d_i(pd_o),
    .rdata_i(rdata), .delay_i(delay), .stall_i(stall),
    .wait_n_o(wait_n), .bus_o(pd_i), .latched_o(latched),
    .latched_adr_o(lat_adr));
  // ====
  // checks and bus cycles
  task automatic check(input string n, input logic [31:0] e,
                       input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic stop_test;
    if (failures == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // 1.7 has no wait-low gate, so a long hold must run out first
  task automatic wait_low;
    while (wait_n !== 1'b0)
      @(posedge clk_i);
  endtask
  // note is {check flag, expected read data}
  task automatic bus(input logic w, input logic [2:0] a,
                     input logic [31:0] d, input logic [32:0] e);
    q.push_back(e);
    lat = 0;
    lo = 1'b0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= {a, 2'b00};
    wb_dat_i <= d;
    do
    begin
      @(posedge clk_i);
      lat++;
      if (rdy === 1'b0)
        lo = 1'b1;
    end
    while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  always @(posedge clk_i)
    if (wb_ack_o === 1'b1 && q.size() > 0)
    begin
      note = q.pop_front();
      if (note[32])
        check("read data", note[31:0], wb_dat_o);
    end
  initial
  begin
    repeat (20000) @(posedge clk_i);
    failures++;
    stop_test();
  end
  // ====
  // scenarios
  initial
  begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    bus(0, 3'h2, 0, {1'b1, 32'h04});
    bus(0, 3'h6, 0, {1'b1, 32'h0});
    check("ready idle", 0, lo);
    check("peripheral reset", 1, prst_n);
    for (int m = 0; m < 2; m++)
    begin
      bus(1, 3'h5, m, 0);
      bus(1, 3'h2, 32'h04, 0);
      for (int i = 0; i < 6; i++)
      begin
        idx = 3'h3 + 3'(i % 2);
        b = 8'($random(seed));
        delay <= 3'($random(seed));
        if (m == 1)
          wait_low();
        bus(1, idx, {24'h0, b}, 0);
        check("port byte", b, latched);
        check("addr strobe", idx == 3'h3, lat_adr);
        check("ready stretched", 1, lo);
        check("ready released", 1, rdy);
        if (m == 1)
        begin
          bus(1, 3'h2, 32'h24, 0);
          wait_low();
        end
        r = 8'($random(seed));
        rdata <= r;
        bus(0, idx, 0, {1'b1, 24'h0, r});
        check("ready released", 1, rdy);
        if (m == 1)
          bus(1, 3'h2, 32'h04, 0);
      end
    end
    stall <= 1'b1;
    for (int m = 1; m >= 0; m--)
    begin
      bus(1, 3'h5, m, 0);
      wait_low();
      bus(1, 3'h4, 32'h5A, 0);
      check("timeout span", 1, lat >= 20 && lat <= 28);
      bus(0, 3'h1, 0, {1'b1, 32'h11});
      bus(1, 3'h1, 32'h01, 0);
      bus(0, 3'h1, 0, {1'b1, 32'h10});
    end
    stall <= 1'b0;
    c = 6'($random(seed));
    bus(1, 3'h2, {26'h0, c}, 0);
    bus(0, 3'h2, 0, {1'b1, 26'h0, c});
    check("idle pins", {~c[0], ~c[1], c[2], ~c[3], c[5]},
          {stb_n, afd_n, init_n, sl_n, dir_o});
    intr_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    check("interrupt", 1, intr_o);
    bus(1, 3'h5, 32'h02, 0);
    check("peripheral reset", 0, prst_n);
    repeat (4) @(posedge clk_i);
    stop_test();
  end
endmodule // tb
`default_nettype wire
